// ==== rtl/sfsr_sysreg.sv ====
`timescale 1ns/1ps
module sfsr_sysreg #(
  parameter int unsigned     DATA_W    = sfsr_pkg::DATA_W,
  // Identification field values; all are arbitrary neutral codes.
  parameter logic [7:0]      ID_IMPL   = 8'h5a,
  parameter logic [6:0]      ID_SUBA   = 7'h00,
  parameter logic [7:0]      ID_PART   = 8'h11,
  parameter logic [3:0]      ID_VAR    = 4'h1,
  parameter logic [3:0]      ID_REV    = 4'h0
) (
  // Clock, enable, reset
  input  wire logic        clk,
  input  wire logic        ce,
  input  wire logic        nrst,
  // Register move request from the core
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic        req_space_fp,
  input  wire logic        req_secure,
  input  wire logic        req_priv,
  input  wire logic [3:0]  req_crn,
  input  wire logic [2:0]  req_op1,
  input  wire logic [3:0]  req_crm,
  input  wire logic [2:0]  req_op2,
  input  wire logic [3:0]  req_fpreg,
  input  wire logic [31:0] req_wdata,
  // Answer to the core
  output logic             resp_valid,
  output logic             resp_undef,
  output logic [31:0]      resp_rdata,
  // Current security state of the core
  input  wire logic        core_secure,
  // Effective controls for the execution units
  output logic             simd_off,
  output logic             upper_regs_off,
  output logic             unit_enable
);

  if (DATA_W != 32) begin : g_width_check
    $error("sfsr_sysreg supports only 32-bit registers");
  end

  typedef struct packed {
    logic [31:0] perm_ctrl;
    logic [31:0] grant;
    logic [31:0] status;
    logic [31:0] exc;
    logic        rsp_v;
    logic        rsp_undef;
    logic [31:0] rdata;
    logic        simd_off;
    logic        upper_off;
  } sfsr_state_t;

  sfsr_state_t s_q;
  sfsr_state_t s_d;

  logic        rst_n;
  logic [31:0] id_word;
  logic [31:0] pc_keep;
  logic [31:0] pc_zero;
  logic [31:0] pc_ones;
  logic [31:0] pc_view;
  logic [31:0] rd_word;
  logic        take;

  sfsr_chk_if u_ck ();

  sfsr_rst_sync u_rst (
    .clk        (clk),
    .ce         (ce),
    .nrst       (nrst),
    .rst_n_sync (rst_n)
  );

  sfsr_access_check u_chk (
    .ck (u_ck.chk)
  );

  assign u_ck.space_fp = req_space_fp;
  assign u_ck.write    = req_write;
  assign u_ck.secure   = req_secure;
  assign u_ck.priv     = req_priv;
  assign u_ck.crn      = req_crn;
  assign u_ck.op1      = req_op1;
  assign u_ck.crm      = req_crm;
  assign u_ck.op2      = req_op2;
  assign u_ck.fpreg    = req_fpreg;
  assign u_ck.perm_a   = s_q.perm_ctrl[sfsr_pkg::PC_CPA_LSB +: 2];
  assign u_ck.grant_a  = s_q.grant[sfsr_pkg::GR_CPA_BIT];
  assign u_ck.unit_en  = s_q.exc[sfsr_pkg::EXC_EN_BIT];

  always_comb begin
    id_word = '0;
    id_word[sfsr_pkg::ID_IMPL_LSB +: 8] = ID_IMPL;
    id_word[sfsr_pkg::ID_HWONLY_BIT]    = 1'b1;
    id_word[sfsr_pkg::ID_SUBA_LSB +: 7] = ID_SUBA;
    id_word[sfsr_pkg::ID_PART_LSB +: 8] = ID_PART;
    id_word[sfsr_pkg::ID_VAR_LSB +: 4]  = ID_VAR;
    id_word[sfsr_pkg::ID_REV_LSB +: 4]  = ID_REV;
  end

  // Non-secure view of the permission control register. Bits forced to
  // one keep their stored secure value underneath, so a later return to
  // the secure view shows what secure software last wrote.
  always_comb begin
    pc_keep = '0;
    pc_zero = '0;
    pc_ones = '0;
    if (!req_secure) begin
      if (s_q.grant[sfsr_pkg::GR_SIMD_BIT]) begin
        pc_keep[sfsr_pkg::PC_SIMD_BIT] = 1'b1;
        pc_ones[sfsr_pkg::PC_SIMD_BIT] = 1'b1;
      end
      if (s_q.grant[sfsr_pkg::GR_UPPER_BIT]) begin
        pc_keep[sfsr_pkg::PC_UPPER_BIT] = 1'b1;
        pc_ones[sfsr_pkg::PC_UPPER_BIT] = 1'b1;
      end
      if (!s_q.grant[sfsr_pkg::GR_CPB_BIT]) begin
        pc_keep[sfsr_pkg::PC_CPB_LSB +: 2] = 2'h3;
        pc_zero[sfsr_pkg::PC_CPB_LSB +: 2] = 2'h3;
      end
      if (!s_q.grant[sfsr_pkg::GR_CPA_BIT]) begin
        pc_keep[sfsr_pkg::PC_CPA_LSB +: 2] = 2'h3;
        pc_zero[sfsr_pkg::PC_CPA_LSB +: 2] = 2'h3;
      end
    end
    pc_view = (s_q.perm_ctrl & ~pc_zero) | pc_ones;
  end

  always_comb begin
    case (u_ck.target)
      sfsr_pkg::TGT_PERM_CTRL: rd_word = pc_view;
      sfsr_pkg::TGT_GRANT:     rd_word = s_q.grant;
      sfsr_pkg::TGT_ID:        rd_word = id_word;
      sfsr_pkg::TGT_STATUS:    rd_word = s_q.status;
      sfsr_pkg::TGT_FEAT_B:    rd_word = sfsr_pkg::FEAT_B_VAL;
      sfsr_pkg::TGT_FEAT_A:    rd_word = sfsr_pkg::FEAT_A_VAL;
      sfsr_pkg::TGT_EXC:       rd_word = s_q.exc;
      default:                 rd_word = '0;
    endcase
  end

  assign take = ce && req_valid;

  always_comb begin
    s_d = s_q;
    if (ce) begin
      s_d.rsp_v     = 1'b0;
      s_d.rsp_undef = 1'b0;
      s_d.simd_off  = s_q.perm_ctrl[sfsr_pkg::PC_SIMD_BIT] |
                      (!core_secure && s_q.grant[sfsr_pkg::GR_SIMD_BIT]);
      s_d.upper_off = s_q.perm_ctrl[sfsr_pkg::PC_UPPER_BIT] |
                      (!core_secure && s_q.grant[sfsr_pkg::GR_UPPER_BIT]);
    end
    if (take) begin
      s_d.rsp_v = 1'b1;
      if (!u_ck.permit) begin
        s_d.rsp_undef = 1'b1;
        s_d.rdata     = '0;
      end else if (!req_write) begin
        s_d.rdata = rd_word;
      end else begin
        s_d.rdata = '0;
        case (u_ck.target)
          sfsr_pkg::TGT_PERM_CTRL: begin
            s_d.perm_ctrl = ((s_q.perm_ctrl & pc_keep) |
                             (req_wdata & ~pc_keep)) & sfsr_pkg::PC_WMASK;
          end
          sfsr_pkg::TGT_GRANT: begin
            s_d.grant = req_wdata & sfsr_pkg::GR_WMASK;
          end
          sfsr_pkg::TGT_STATUS: begin
            s_d.status = req_wdata;
          end
          sfsr_pkg::TGT_EXC: begin
            s_d.exc = req_wdata;
          end
          // Identification, feature and reserved writes are dropped.
          default: begin
            s_d.rdata = '0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q           <= '0;
      s_q.perm_ctrl <= sfsr_pkg::PC_RST;
      s_q.grant     <= sfsr_pkg::GR_RST;
      s_q.status    <= sfsr_pkg::STATUS_RST;
      s_q.exc       <= sfsr_pkg::EXC_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign resp_valid     = s_q.rsp_v;
  assign resp_undef     = s_q.rsp_undef;
  assign resp_rdata     = s_q.rdata;
  assign simd_off       = s_q.simd_off;
  assign upper_regs_off = s_q.upper_off;
  assign unit_enable    = s_q.exc[sfsr_pkg::EXC_EN_BIT];

endmodule

// ==== rtl/sfsr_pkg.sv ====
package sfsr_pkg;

  localparam int unsigned DATA_W = 32;

  // Coprocessor 15 coordinates of the two control registers.
  localparam logic [3:0] CP15_CRN       = 4'h1;
  localparam logic [2:0] CP15_OP1       = 3'h0;
  localparam logic [3:0] CRM_PERM_CTRL  = 4'h0;
  localparam logic [3:0] CRM_GRANT      = 4'h1;
  localparam logic [2:0] CP15_OP2       = 3'h2;

  // System register numbers used by the move instructions.
  localparam logic [3:0] FPREG_ID       = 4'h0;
  localparam logic [3:0] FPREG_STATUS   = 4'h1;
  localparam logic [3:0] FPREG_FEAT_B   = 4'h6;
  localparam logic [3:0] FPREG_FEAT_A   = 4'h7;
  localparam logic [3:0] FPREG_EXC      = 4'h8;

  // Grant register fields.
  localparam int unsigned GR_SIMD_BIT   = 15;
  localparam int unsigned GR_UPPER_BIT  = 14;
  localparam int unsigned GR_CPB_BIT    = 11;
  localparam int unsigned GR_CPA_BIT    = 10;
  localparam logic [31:0] GR_WMASK      = 32'h0000cc00;
  localparam logic [31:0] GR_RST        = 32'h00000000;

  // Permission control register fields.
  localparam int unsigned PC_SIMD_BIT   = 31;
  localparam int unsigned PC_UPPER_BIT  = 30;
  localparam int unsigned PC_CPB_LSB    = 22;
  localparam int unsigned PC_CPA_LSB    = 20;
  localparam logic [31:0] PC_WMASK      = 32'hc0f00000;
  localparam logic [31:0] PC_RST        = 32'h00000000;
  localparam logic [1:0]  PERM_PRIV     = 2'h1;
  localparam logic [1:0]  PERM_ALL      = 2'h3;

  // Status, exception and feature registers.
  localparam int unsigned EXC_EN_BIT    = 30;
  localparam logic [31:0] STATUS_RST    = 32'h00000000;
  localparam logic [31:0] EXC_RST       = 32'h00000000;
  localparam logic [31:0] FEAT_B_VAL    = 32'h01111111;
  localparam logic [31:0] FEAT_A_VAL    = 32'h10110222;

  // Identification register field positions.
  localparam int unsigned ID_IMPL_LSB   = 24;
  localparam int unsigned ID_HWONLY_BIT = 23;
  localparam int unsigned ID_SUBA_LSB   = 16;
  localparam int unsigned ID_PART_LSB   = 8;
  localparam int unsigned ID_VAR_LSB    = 4;
  localparam int unsigned ID_REV_LSB    = 0;

  typedef enum logic [2:0] {
    TGT_NONE,
    TGT_PERM_CTRL,
    TGT_GRANT,
    TGT_ID,
    TGT_STATUS,
    TGT_FEAT_B,
    TGT_FEAT_A,
    TGT_EXC
  } sfsr_target_t;

endpackage

// ==== rtl/sfsr_chk_if.sv ====
`timescale 1ns/1ps
interface sfsr_chk_if;
  logic                  space_fp;
  logic                  write;
  logic                  secure;
  logic                  priv;
  logic [3:0]            crn;
  logic [2:0]            op1;
  logic [3:0]            crm;
  logic [2:0]            op2;
  logic [3:0]            fpreg;
  logic [1:0]            perm_a;
  logic                  grant_a;
  logic                  unit_en;
  sfsr_pkg::sfsr_target_t target;
  logic                  permit;

  modport top (
    output space_fp, write, secure, priv, crn, op1, crm, op2, fpreg,
    output perm_a, grant_a, unit_en,
    input  target, permit
  );

  modport chk (
    input  space_fp, write, secure, priv, crn, op1, crm, op2, fpreg,
    input  perm_a, grant_a, unit_en,
    output target, permit
  );
endinterface

// ==== rtl/sfsr_rst_sync.sv ====
`timescale 1ns/1ps
module sfsr_rst_sync (
  // Clock, enable and raw reset
  input  wire logic clk,
  input  wire logic ce,
  input  wire logic nrst,
  // Released reset
  output logic      rst_n_sync
);
  typedef struct packed {
    logic [1:0] shift;
  } sfsr_rs_state_t;

  sfsr_rs_state_t s_q;
  sfsr_rs_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (ce) begin
      s_d.shift = {s_q.shift[0], 1'b1};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rst_n_sync = s_q.shift[1];
endmodule

// ==== rtl/sfsr_access_check.sv ====
`timescale 1ns/1ps
module sfsr_access_check (
  // Request and state in, verdict out
  sfsr_chk_if.chk ck
);
  logic coproc_ok;

  // Coprocessor a must be granted to the current state and mode before
  // any floating-point system register move is permitted.
  always_comb begin
    coproc_ok = (ck.secure || ck.grant_a) &&
                ((ck.perm_a == sfsr_pkg::PERM_ALL) ||
                 ((ck.perm_a == sfsr_pkg::PERM_PRIV) && ck.priv));
  end

  always_comb begin
    ck.target = sfsr_pkg::TGT_NONE;
    ck.permit = 1'b0;
    if (!ck.space_fp) begin
      if ((ck.crn == sfsr_pkg::CP15_CRN) && (ck.op1 == sfsr_pkg::CP15_OP1) &&
          (ck.op2 == sfsr_pkg::CP15_OP2) && (ck.crm == sfsr_pkg::CRM_PERM_CTRL)) begin
        ck.target = sfsr_pkg::TGT_PERM_CTRL;
        ck.permit = ck.priv;
      end else if ((ck.crn == sfsr_pkg::CP15_CRN) && (ck.op1 == sfsr_pkg::CP15_OP1) &&
                   (ck.op2 == sfsr_pkg::CP15_OP2) && (ck.crm == sfsr_pkg::CRM_GRANT)) begin
        ck.target = sfsr_pkg::TGT_GRANT;
        ck.permit = ck.priv && (ck.secure || !ck.write);
      end else begin
        ck.permit = ck.priv;
      end
    end else begin
      case (ck.fpreg)
        sfsr_pkg::FPREG_ID:     ck.target = sfsr_pkg::TGT_ID;
        sfsr_pkg::FPREG_STATUS: ck.target = sfsr_pkg::TGT_STATUS;
        sfsr_pkg::FPREG_FEAT_B: ck.target = sfsr_pkg::TGT_FEAT_B;
        sfsr_pkg::FPREG_FEAT_A: ck.target = sfsr_pkg::TGT_FEAT_A;
        sfsr_pkg::FPREG_EXC:    ck.target = sfsr_pkg::TGT_EXC;
        default:                ck.target = sfsr_pkg::TGT_NONE;
      endcase
      if (ck.fpreg == sfsr_pkg::FPREG_STATUS) begin
        ck.permit = coproc_ok && ck.unit_en;
      end else begin
        ck.permit = coproc_ok && ck.priv;
      end
    end
  end
endmodule

// ==== tb/sfsr_sysreg_checker.sv ====
`timescale 1ns/1ps
module sfsr_sysreg_checker (
  // Clock, enable and reset
  input wire logic        clk,
  input wire logic        ce,
  input wire logic        nrst,
  // Request
  input wire logic        req_valid,
  input wire logic        req_write,
  input wire logic        req_space_fp,
  input wire logic        req_secure,
  input wire logic        req_priv,
  input wire logic [3:0]  req_crn,
  input wire logic [2:0]  req_op1,
  input wire logic [3:0]  req_crm,
  input wire logic [2:0]  req_op2,
  input wire logic [3:0]  req_fpreg,
  // Answer and state
  input wire logic        resp_valid,
  input wire logic        resp_undef,
  input wire logic [31:0] resp_rdata,
  input wire logic        unit_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence take;
    req_valid && ce;
  endsequence
  sequence fp_read(logic [3:0] r);
    req_valid && ce && req_space_fp && !req_write && req_fpreg == r;
  endsequence
  sequence grant_req;
    req_valid && ce && !req_space_fp && req_crn == 4'h1 && req_op1 == 3'h0
      && req_crm == 4'h1 && req_op2 == 3'h2;
  endsequence

  a_answer_next_cycle: assert property (take |=> resp_valid)
    else $error("request got no answer");
  a_no_stray_answer: assert property (!(req_valid && ce) |=> !resp_valid)
    else $error("answer without request");
  a_trap_reads_zero: assert property (resp_valid && resp_undef |-> resp_rdata == 32'h0)
    else $error("trap returned data");
  a_user_grant_trap: assert property ((grant_req ##0 !req_priv) |=> resp_undef)
    else $error("user grant access not trapped");
  a_ns_grant_write: assert property ((grant_req ##0 req_write && req_priv && !req_secure)
    |=> resp_undef)
    else $error("non-secure grant write not trapped");
  a_user_fp_trap: assert property (req_valid && ce && req_space_fp && !req_priv
    && req_fpreg != sfsr_pkg::FPREG_STATUS |=> resp_undef)
    else $error("user access to privileged register not trapped");
  a_status_gated: assert property ((fp_read(sfsr_pkg::FPREG_STATUS) ##0 !unit_enable)
    |=> resp_undef)
    else $error("status read while unit disabled");
  a_feat_a_const: assert property ((fp_read(sfsr_pkg::FPREG_FEAT_A) ##1 !resp_undef)
    |-> resp_rdata == sfsr_pkg::FEAT_A_VAL)
    else $error("feature a value wrong");
  a_feat_b_const: assert property ((fp_read(sfsr_pkg::FPREG_FEAT_B) ##1 !resp_undef)
    |-> resp_rdata == sfsr_pkg::FEAT_B_VAL)
    else $error("feature b value wrong");
endmodule

// ==== tb/sfsr_core_model.sv ====
`timescale 1ns/1ps
module sfsr_core_model (
  // Clock
  input  wire logic        clk,
  // Request
  output logic             req_valid,
  output logic             req_write,
  output logic             req_space_fp,
  output logic             req_secure,
  output logic             req_priv,
  output logic [3:0]       req_crn,
  output logic [2:0]       req_op1,
  output logic [3:0]       req_crm,
  output logic [2:0]       req_op2,
  output logic [3:0]       req_fpreg,
  output logic [31:0]      req_wdata,
  // Answer
  input  wire logic        resp_valid,
  input  wire logic        resp_undef,
  input  wire logic [31:0] resp_rdata
);
  initial begin
    {req_valid, req_write, req_space_fp, req_secure, req_priv} = 5'h0;
    {req_crn, req_op1, req_crm, req_op2, req_fpreg} = 18'h0;
    req_wdata = 32'h0;
  end

  task automatic acc(input logic w, fp, s, p, input logic [3:0] a,
                     input logic [31:0] wd, output logic u, output logic [31:0] rd);
    @(negedge clk);
    {req_valid, req_write, req_space_fp, req_secure, req_priv} = {1'b1, w, fp, s, p};
    {req_crn, req_op1, req_op2} = {4'h1, 3'h0, 3'h2};
    req_crm = a;
    req_fpreg = a;
    req_wdata = wd;
    @(negedge clk);
    req_valid = 1'b0;
    u = resp_valid ? resp_undef : 1'bx;
    rd = resp_rdata;
    // A released data bus must not keep showing the last word.
    req_wdata = ~wd;
  endtask
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0;
  logic        ce = 1'b1;
  logic        nrst = 1'b0;
  logic        core_secure = 1'b1;
  logic        rv, rw, rf, rs, rp, vld, und, so, uo, ue, u;
  logic [3:0]  crn, crm, fpr;
  logic [2:0]  op1, op2;
  logic [31:0] wd, rdata, d;
  int          n_fail = 0;
  int          checks = 0;

  always #25 clk = ~clk;

  sfsr_core_model u_core (.clk(clk), .req_valid(rv), .req_write(rw), .req_space_fp(rf),
    .req_secure(rs), .req_priv(rp), .req_crn(crn), .req_op1(op1), .req_crm(crm),
    .req_op2(op2), .req_fpreg(fpr), .req_wdata(wd), .resp_valid(vld), .resp_undef(und),
    .resp_rdata(rdata));

  sfsr_sysreg u_dut (.clk(clk), .ce(ce), .nrst(nrst), .req_valid(rv), .req_write(rw),
    .req_space_fp(rf), .req_secure(rs), .req_priv(rp), .req_crn(crn), .req_op1(op1),
    .req_crm(crm), .req_op2(op2), .req_fpreg(fpr), .req_wdata(wd), .resp_valid(vld),
    .resp_undef(und), .resp_rdata(rdata), .core_secure(core_secure), .simd_off(so),
    .upper_regs_off(uo), .unit_enable(ue));

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic op(input logic w, fp, s, p, input logic [3:0] a, input logic [31:0] wv,
                    input logic eu, input logic [31:0] ed);
    u_core.acc(w, fp, s, p, a, wv, u, d);
    chk({u, d}, {eu, ed});
  endtask

  task automatic report_and_stop;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #50000;
    n_fail++;
    report_and_stop();
  end

  initial begin
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    op(0, 0, 1, 1, 4'h1, 32'h0, 0, 32'h0);
    op(1, 0, 1, 1, 4'h0, 32'hffffffff, 0, 32'h0);
    op(0, 0, 1, 1, 4'h0, 32'h0, 0, 32'hc0f00000);
    chk({31'h0, so, uo}, 33'h3);
    op(1, 0, 1, 1, 4'h0, 32'h00f00000, 0, 32'h0);
    op(0, 0, 1, 1, 4'h0, 32'h0, 0, 32'h00f00000);
    op(0, 1, 1, 1, 4'h6, 32'h0, 0, 32'h01111111);
    op(1, 1, 1, 1, 4'h7, 32'hffffffff, 0, 32'h0);
    op(0, 1, 1, 1, 4'h7, 32'h0, 0, 32'h10110222);
    op(0, 1, 1, 1, 4'h0, 32'h0, 0, 32'h5a801110);
    op(0, 1, 1, 0, 4'h0, 32'h0, 1, 32'h0);
    op(0, 1, 1, 1, 4'h1, 32'h0, 1, 32'h0);
    op(0, 1, 1, 1, 4'h8, 32'h0, 0, 32'h0);
    op(1, 1, 1, 0, 4'h8, 32'hffffffff, 1, 32'h0);
    op(1, 1, 1, 1, 4'h8, 32'h40000000, 0, 32'h0);
    op(0, 1, 1, 1, 4'h8, 32'h0, 0, 32'h40000000);
    op(0, 1, 1, 1, 4'h1, 32'h0, 0, 32'h0);
    op(1, 1, 1, 0, 4'h1, 32'h12345678, 0, 32'h0);
    op(0, 1, 1, 0, 4'h1, 32'h0, 0, 32'h12345678);
    op(1, 1, 1, 1, 4'h3, 32'hffffffff, 0, 32'h0);
    op(0, 1, 1, 1, 4'h3, 32'h0, 0, 32'h0);
    op(1, 0, 1, 1, 4'h5, 32'hffffffff, 0, 32'h0);
    op(0, 0, 1, 1, 4'h5, 32'h0, 0, 32'h0);
    op(1, 0, 1, 0, 4'h1, 32'hffffffff, 1, 32'h0);
    op(0, 0, 0, 0, 4'h1, 32'h0, 1, 32'h0);
    op(1, 0, 1, 1, 4'h1, 32'hffffffff, 0, 32'h0);
    op(0, 0, 1, 1, 4'h1, 32'h0, 0, 32'h0000cc00);
    op(1, 0, 0, 1, 4'h1, 32'h0, 1, 32'h0);
    op(0, 0, 0, 1, 4'h1, 32'h0, 0, 32'h0000cc00);
    op(1, 0, 1, 1, 4'h1, 32'h0000c000, 0, 32'h0);
    chk({31'h0, so, uo}, 33'h0);
    core_secure = 1'b0;
    op(0, 0, 0, 1, 4'h0, 32'h0, 0, 32'hc0000000);
    op(1, 0, 0, 1, 4'h0, 32'h0, 0, 32'h0);
    op(0, 0, 1, 1, 4'h0, 32'h0, 0, 32'h00f00000);
    chk({31'h0, so, uo}, 33'h3);
    op(0, 1, 0, 1, 4'h8, 32'h0, 1, 32'h0);
    op(1, 0, 1, 1, 4'h1, 32'h00000400, 0, 32'h0);
    op(0, 1, 0, 1, 4'h8, 32'h0, 0, 32'h40000000);
    chk({31'h0, so, uo}, 33'h0);
    // A request made while the clock enable is low must not be taken.
    @(negedge clk);
    ce = 1'b0;
    u_core.acc(1, 1, 1, 1, 4'h8, 32'h0, u, d);
    chk({32'h0, vld}, 33'h0);
    ce = 1'b1;
    op(0, 1, 1, 1, 4'h8, 32'h0, 0, 32'h40000000);
    // A reset in mid-run must bring every register back to its reset value.
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    chk({32'h0, ue}, 33'h0);
    op(0, 0, 1, 1, 4'h1, 32'h0, 0, 32'h0);
    op(0, 1, 1, 1, 4'h8, 32'h0, 1, 32'h0);
    op(1, 0, 1, 1, 4'h0, 32'h00f00000, 0, 32'h0);
    op(0, 1, 1, 1, 4'h8, 32'h0, 0, 32'h0);
    op(1, 1, 1, 1, 4'h8, 32'h40000000, 0, 32'h0);
    chk({32'h0, ue}, 33'h1);
    op(0, 1, 1, 1, 4'h1, 32'h0, 0, 32'h0);
    report_and_stop();
  end
endmodule

bind sfsr_sysreg sfsr_sysreg_checker u_sva (.clk(clk), .ce(ce), .nrst(nrst),
  .req_valid(req_valid), .req_write(req_write), .req_space_fp(req_space_fp),
  .req_secure(req_secure), .req_priv(req_priv), .req_crn(req_crn), .req_op1(req_op1),
  .req_crm(req_crm), .req_op2(req_op2), .req_fpreg(req_fpreg), .resp_valid(resp_valid),
  .resp_undef(resp_undef), .resp_rdata(resp_rdata), .unit_enable(unit_enable));
